// ==== logic/pec_top.sv ====
// Control port pin mux: pin roles, pullups and drive strength per operating mode
// Assumes a single 20 MHz clock, synchronous inputs and a stable mode after reset
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "pec_cfg.svh"

module pec_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Operating mode and bus timing controls
  input  wire pec_pkg::pec_mode_type mode,
  input  wire logic                  internal_visibility,
  input  wire logic                  bus_clock_stretch,
  input  wire logic                  tag_enable,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Bus-control sources
  input  wire logic                  data_bus_enable,
  input  wire logic                  clock_module_test,
  input  wire logic [1:0]            pipe_status,
  input  wire logic                  bus_clock,
  input  wire logic                  low_byte_strobe,
  input  wire logic                  read_write,
  // Control port pins
  input  wire logic [7:0]            pin_in,
  output logic      [7:0]            pin_out,
  output logic      [7:0]            pin_oe,
  output logic      [7:0]            pin_pullup,
  // Address/data and control port pad controls
  output logic                       high_addr_port_pullup,
  output logic                       low_addr_port_pullup,
  output logic                       control_port_reduced_drive,
  output logic                       low_addr_port_reduced_drive,
  output logic                       high_addr_port_reduced_drive,
  // Debug tag
  output logic                       low_byte_instruction_tag
);
  import pec_pkg::*;

  // --------------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------------
  logic single;
  logic special;
  logic norm_exp;
  logic spec_exp;
  logic periph;
  logic addr_bus;

  always_comb begin
    single   = pec_single(mode);
    special  = pec_special(mode);
    norm_exp = pec_norm_exp(mode);
    spec_exp = pec_spec_exp(mode);
    periph   = (mode == PEC_PER);
    addr_bus = !single;
  end

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  logic       wr_port_e_pin_assignment;
  logic       wr_pull;
  logic       wr_drive;
  logic       wr_dir;
  logic       wr_data;
  logic [7:0] port_e_pin_assignment;
  logic [7:0] drive;
  logic [7:0] port_e_pin_assignment_always;
  logic [7:0] port_e_pin_assignment_frozen;

  always_comb begin
    wr_port_e_pin_assignment  = reg_wr && (reg_addr == `PEC_OFS_PORT_E_PIN_ASSIGNMENT) && !periph;
    wr_pull  = reg_wr && (reg_addr == `PEC_OFS_PULL) && !periph;
    wr_drive = reg_wr && (reg_addr == `PEC_OFS_DRIVE) && !periph;
    wr_dir   = reg_wr && (reg_addr == `PEC_OFS_DIR) && !periph;
    wr_data  = reg_wr && (reg_addr == `PEC_OFS_DATA) && !periph;
    // Bus clock off bit: anytime in special single-chip, frozen at 0 when expanded
    port_e_pin_assignment_always = (mode == PEC_SSC) ? `PEC_NOBCK_MASK : 8'h00;
    port_e_pin_assignment_frozen = ~`PEC_PORT_E_PIN_ASSIGNMENT_MASK | (single ? 8'h00 : `PEC_NOBCK_MASK);
  end

  // Reset value follows the mode so bus-control pins are live at once
  pec_wlock #(.WIDTH(8)) u_port_e_pin_assignment (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .rst_value   (pec_port_e_pin_assignment_reset(mode)),
    .special     (special),
    .always_mask (port_e_pin_assignment_always),
    .frozen_mask (port_e_pin_assignment_frozen),
    .wr          (wr_port_e_pin_assignment),
    .wr_data     (reg_wdata),
    .value       (port_e_pin_assignment),
    .first_done  ()
  );

  pec_wlock #(.WIDTH(8)) u_drive (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .rst_value   (`PEC_DRIVE_RST),
    .special     (special),
    .always_mask (8'h00),
    .frozen_mask (~`PEC_DRIVE_MASK),
    .wr          (wr_drive),
    .wr_data     (reg_wdata),
    .value       (drive),
    .first_done  ()
  );

  // --------------------------------------------------------------------------
  // Freely writable registers
  // --------------------------------------------------------------------------
  logic [7:0] pull;
  logic [7:0] dir;
  logic [7:0] data;
  logic [7:0] next_pull;
  logic [7:0] next_dir;
  logic [7:0] next_data;

  always_comb begin
    next_pull = wr_pull ? (reg_wdata & `PEC_PULL_MASK) : pull;
    next_dir  = wr_dir ? (reg_wdata & `PEC_DIR_MASK) : dir;
    next_data = wr_data ? reg_wdata : data;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pull <= `PEC_PULL_RST;
      dir  <= `PEC_DIR_RST;
      data <= `PEC_DATA_RST;
    end else begin
      pull <= next_pull;
      dir  <= next_dir;
      data <= next_data;
    end
  end

  // --------------------------------------------------------------------------
  // Pin role selection
  // --------------------------------------------------------------------------
  logic       alt_dbe;
  logic       alt_ckt;
  logic       alt_pipe;
  logic       alt_eclk;
  logic       alt_strb;
  logic       alt_rw;
  logic       tag_window;
  logic [7:0] alt;
  logic [7:0] alt_val;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] next_pin_pullup;

  always_comb begin
    alt_dbe   = !port_e_pin_assignment[`PEC_DBOFF_BIT];
    alt_pipe  = port_e_pin_assignment[`PEC_PIPEN_BIT] && !single;
    alt_ckt   = port_e_pin_assignment[`PEC_CKTST_BIT] && !single && !norm_exp && !alt_pipe;
    alt_eclk  = !port_e_pin_assignment[`PEC_NOBCK_BIT] &&
                (!single || internal_visibility || !bus_clock_stretch);
    alt_strb  = port_e_pin_assignment[`PEC_STREN_BIT] && !single && (mode != PEC_NEXN);
    alt_rw    = port_e_pin_assignment[`PEC_RWEN_BIT] && !single;
    // While tagging the tool owns pin 3; a registered release could not track the bus clock edge
    tag_window = spec_exp && alt_strb && tag_enable;
    alt     = {alt_dbe, alt_pipe | alt_ckt, alt_pipe, alt_eclk, alt_strb, alt_rw, 2'b00};
    alt_val = {data_bus_enable,
               alt_pipe ? pipe_status[1] : clock_module_test,
               pipe_status[0], bus_clock, low_byte_strobe, read_write, 2'b00};
    next_pin_out = (alt & alt_val) | (~alt & data);
    // Role wins over the direction bit; pins 1 and 0 never drive
    next_pin_oe = ((alt | dir) & `PEC_DIR_MASK);
    if (tag_window) begin
      next_pin_oe[3] = 1'b0;
    end
    next_pin_pullup = (pull[`PEC_PORTE_BIT] ? (`PEC_PULL_SW_MASK & ~next_pin_oe) : 8'h00)
                      | `PEC_PULL_ON_MASK;
  end

  // --------------------------------------------------------------------------
  // Pad outputs and tag detect
  // --------------------------------------------------------------------------
  logic prev_bus_clock;
  logic next_tag;
  logic next_high_pull;
  logic next_low_pull;

  always_comb begin
    // Only a released pin can carry the tag, never the block's own strobe level
    next_tag       = tag_window && !pin_oe[3] && prev_bus_clock && !bus_clock && !pin_in[3];
    next_high_pull = pull[`PEC_PORTA_BIT] && !addr_bus;
    next_low_pull  = pull[`PEC_PORTB_BIT] && !addr_bus;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out                      <= 8'h00;
      pin_oe                       <= 8'h00;
      pin_pullup                   <= `PEC_PULL_ON_MASK;
      high_addr_port_pullup        <= 1'b0;
      low_addr_port_pullup         <= 1'b0;
      control_port_reduced_drive   <= 1'b0;
      low_addr_port_reduced_drive  <= 1'b0;
      high_addr_port_reduced_drive <= 1'b0;
      prev_bus_clock               <= 1'b0;
      low_byte_instruction_tag     <= 1'b0;
    end else begin
      pin_out                      <= next_pin_out;
      pin_oe                       <= next_pin_oe;
      pin_pullup                   <= next_pin_pullup;
      high_addr_port_pullup        <= next_high_pull;
      low_addr_port_pullup         <= next_low_pull;
      control_port_reduced_drive   <= drive[`PEC_PORTE_BIT];
      low_addr_port_reduced_drive  <= drive[`PEC_PORTB_BIT];
      high_addr_port_reduced_drive <= drive[`PEC_PORTA_BIT];
      prev_bus_clock               <= bus_clock;
      low_byte_instruction_tag     <= next_tag;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd && !periph) begin
      case (reg_addr)
        `PEC_OFS_PORT_E_PIN_ASSIGNMENT:  next_rdata = port_e_pin_assignment & `PEC_PORT_E_PIN_ASSIGNMENT_MASK;
        `PEC_OFS_PULL:  next_rdata = pull;
        `PEC_OFS_DRIVE: next_rdata = drive & `PEC_DRIVE_MASK;
        `PEC_OFS_DIR:   next_rdata = dir;
        // Inputs read the pin, outputs read back what is driven
        `PEC_OFS_DATA:  next_rdata = (pin_oe & pin_out) | (~pin_oe & pin_in);
        `PEC_OFS_PINS:  next_rdata = pin_in;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_port_e_pin_assignment_reset: assert property ($past(sys_rst) |-> port_e_pin_assignment == pec_port_e_pin_assignment_reset(mode))
    else $error("assignment value after reset does not match mode");
  a_rw_override: assert property (alt_rw && !dir[2] |=> pin_oe[2] && pin_out[2] == $past(read_write))
    else $error("read/write pin not driven by bus role");
  a_dbe_pin: assert property (!port_e_pin_assignment[`PEC_DBOFF_BIT] |=> pin_oe[7] && pin_out[7] == $past(data_bus_enable))
    else $error("data enable missing on pin 7");
  a_pipe_wins: assert property (alt_pipe |=> pin_out[6:5] == $past(pipe_status) && pin_oe[6:5] == 2'b11)
    else $error("pipe status not shown on pins 6 and 5");
  a_single_gpio: assert property (single && !alt_eclk |=> pin_oe[6:2] == $past(dir[6:2]))
    else $error("single-chip pin took a bus role");
  a_peri_hidden: assert property (periph && reg_rd |=> reg_rdata == 8'h00)
    else $error("register visible in peripheral mode");
  a_input_only: assert property (pin_oe[1:0] == 2'b00 ##1 pin_oe[1:0] == 2'b00)
    else $error("input-only pin driven");
  a_pull_fixed: assert property (pin_pullup[6:4] == 3'b000 && pin_pullup[1])
    else $error("fixed pullup pattern broken");
  a_pull_input: assert property (pull[`PEC_PORTE_BIT] |=> pin_pullup[7] == !pin_oe[7])
    else $error("pullup on a driven pin");
  a_bus_nopull: assert property (addr_bus |=> !high_addr_port_pullup && !low_addr_port_pullup)
    else $error("address port pullup on while bus active");
  a_bus_clock_kept: assert property (!single && !periph |-> !port_e_pin_assignment[`PEC_NOBCK_BIT])
    else $error("bus clock disabled in expanded mode");

endmodule

`default_nettype wire

// ==== inc/pec_cfg.svh ====
// Offsets, field positions and reset values of the control port pin mux
// Assumes an 8-bit local register address and 8-bit register data
// What this block does
// - A pin given a bus-control role ignores its direction bit.
// - Normal single-chip reset leaves every control port pin as general I/O.
// - Special single-chip reset enables only the bus clock output.
// - Normal expanded reset enables only the bus clock; strobe and read/write stay off.
// - Special expanded reset enables pipe status, bus clock, read/write and low strobe.
// - Peripheral mode hides the pin assignment register from reads and writes.
// - Normal modes take only the first assignment write; special modes skip the first.
// - Data enable off bit 0 puts data enable on pin 7, else general I/O.
// - Pin 6 shows clock test output outside single-chip and normal expanded; pipe wins.
// - Pipe enable outside single-chip drives pipe status on pins 6 and 5.
// - No-bus-clock bit stays 0 expanded, once normal single-chip, anytime special single-chip.
// - Single-chip pin 4 carries bus clock only if bit clear and visibility or no stretch.
// - Low strobe enable drives pin 3 except single-chip, normal expanded narrow and special expanded while tag enable is set.
// - Read/write enable outside single-chip drives read/write on pin 2.
// - Pullups act only on pins currently configured as inputs.
// - Control port pullup bit covers pins 7,3,2,0; pin 1 always, pins 6-4 never.
// - Address/data port pullups stay off while that port serves the external bus.
// - Reduced drive register takes one write normal; special skips first write.
// - Each reduced drive bit reduces all outputs of its port; 0 is full drive.
// - Peripheral mode removes pullup and reduced drive registers from the map.
// - Pins 1 and 0 are input-only and readable in every mode but peripheral.
`ifndef PEC_CFG_SVH
`define PEC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PEC_OFS_DATA        8'h08
`define PEC_OFS_DIR         8'h09
`define PEC_OFS_PORT_E_PIN_ASSIGNMENT        8'h0a
`define PEC_OFS_PULL        8'h0c
`define PEC_OFS_DRIVE       8'h0d
`define PEC_OFS_PINS        8'h0e

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PEC_DBOFF_BIT       7
`define PEC_CKTST_BIT       6
`define PEC_PIPEN_BIT       5
`define PEC_NOBCK_BIT       4
`define PEC_STREN_BIT       3
`define PEC_RWEN_BIT        2
`define PEC_PORTE_BIT       4
`define PEC_PORTB_BIT       1
`define PEC_PORTA_BIT       0

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define PEC_PORT_E_PIN_ASSIGNMENT_MASK       8'hfc
`define PEC_PULL_MASK       8'h13
`define PEC_DRIVE_MASK      8'h13
`define PEC_DIR_MASK        8'hfc
`define PEC_NOBCK_MASK      8'h10
`define PEC_PULL_SW_MASK    8'h8d
`define PEC_PULL_ON_MASK    8'h02
`define PEC_PORT_E_PIN_ASSIGNMENT_RST_NSC    8'h90
`define PEC_PORT_E_PIN_ASSIGNMENT_RST_SSC    8'h80
`define PEC_PORT_E_PIN_ASSIGNMENT_RST_NEX    8'h80
`define PEC_PORT_E_PIN_ASSIGNMENT_RST_SEX    8'hac
`define PEC_PULL_RST        8'h00
`define PEC_DRIVE_RST       8'h00
`define PEC_DIR_RST         8'h00
`define PEC_DATA_RST        8'h00

`endif

// ==== inc/pec_pkg.sv ====
// Types and mode decoding for the control port pin mux
// Assumes pec_cfg.svh is on the include path
`include "pec_cfg.svh"

package pec_pkg;

  // Operating mode as seen by the pin mux
  typedef enum logic [2:0] {
    PEC_NSC  = 3'h0,
    PEC_SSC  = 3'h1,
    PEC_NEXN = 3'h2,
    PEC_NEXW = 3'h3,
    PEC_SEXN = 3'h4,
    PEC_SEXW = 3'h5,
    PEC_PER  = 3'h6
  } pec_mode_type;

  function automatic logic pec_single(input pec_mode_type m);
    return (m == PEC_NSC) || (m == PEC_SSC);
  endfunction

  function automatic logic pec_special(input pec_mode_type m);
    return (m == PEC_SSC) || (m == PEC_SEXN) || (m == PEC_SEXW);
  endfunction

  function automatic logic pec_norm_exp(input pec_mode_type m);
    return (m == PEC_NEXN) || (m == PEC_NEXW);
  endfunction

  function automatic logic pec_spec_exp(input pec_mode_type m);
    return (m == PEC_SEXN) || (m == PEC_SEXW);
  endfunction

  function automatic logic [7:0] pec_port_e_pin_assignment_reset(input pec_mode_type m);
    case (m)
      PEC_SSC:           return `PEC_PORT_E_PIN_ASSIGNMENT_RST_SSC;
      PEC_NEXN, PEC_NEXW: return `PEC_PORT_E_PIN_ASSIGNMENT_RST_NEX;
      PEC_SEXN, PEC_SEXW: return `PEC_PORT_E_PIN_ASSIGNMENT_RST_SEX;
      default:           return `PEC_PORT_E_PIN_ASSIGNMENT_RST_NSC;
    endcase
  endfunction

endpackage

// ==== logic/pec_wlock.sv ====
// Write-limited register: first write only in normal modes, all but first in special
// Assumes write strobes are one cycle long and the mode is stable after reset
`timescale 1ns/100ps
`default_nettype none

module pec_wlock #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Write policy
  input  wire logic [WIDTH-1:0] rst_value,
  input  wire logic             special,
  input  wire logic [WIDTH-1:0] always_mask,
  input  wire logic [WIDTH-1:0] frozen_mask,
  // Write port
  input  wire logic             wr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Stored state
  output logic      [WIDTH-1:0] value,
  output logic                  first_done
);
  import pec_pkg::*;

  logic [WIDTH-1:0] next_value;
  logic             next_first_done;
  logic             limited_ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  always_comb begin
    limited_ok      = special ? first_done : !first_done;
    next_first_done = first_done | wr;
    for (int i = 0; i < WIDTH; i++) begin
      if (frozen_mask[i]) begin
        next_value[i] = rst_value[i];
      end else if (wr && (always_mask[i] || limited_ok)) begin
        next_value[i] = wr_data[i];
      end else begin
        next_value[i] = value[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value      <= rst_value;
      first_done <= 1'b0;
    end else begin
      value      <= next_value;
      first_done <= next_first_done;
    end
  end

  a_normal_lock: assert property (!special && first_done && wr |=>
                                   ((value ^ $past(value)) & ~$past(always_mask)) == '0)
    else $error("normal mode accepted a second write");
  a_special_skip: assert property (special && !first_done && wr |=>
                                    ((value ^ $past(value)) & ~$past(always_mask)) == '0)
    else $error("special mode accepted the first write");
  a_later_take: assert property (special && first_done && wr |=>
                                  (value & ~$past(frozen_mask)) == ($past(wr_data) & ~$past(frozen_mask)))
    else $error("special mode dropped a later write");

endmodule

`default_nettype wire

// ==== bench/pec_far_side.sv ====
// Model of the external memories and peripherals on the control port pins
// Assumes pin enables are high while the pin mux drives a pin
`timescale 1ns/100ps
`default_nettype none

module pec_far_side (
  // Clock
  input  wire logic       clk,
  // Pins as the pin mux drives them
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  // Tagging request and bus clock
  input  wire logic       bus_clock,
  input  wire logic       tag_req,
  // Resolved pin levels
  output logic      [7:0] pin_in
);
  logic [7:0] float_pat = 8'h55;
  logic       tag_low;

  // Undriven pins without pullup toggle so a stale value never passes
  always_ff @(posedge clk) begin
    float_pat <= ~float_pat;
  end

  // Low on the strobe pin while the bus clock is low and the pin is released
  assign tag_low = tag_req && !bus_clock && !pin_oe[3];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (i == 3 && tag_low) pin_in[i] = 1'b0;
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_pat[i];
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_pec_top.sv ====
// Self-checking bench for the control port pin mux
// Assumes the far side model closes the pin loop back into the design
`timescale 1ns/100ps
`default_nettype none

module test_pec_top;
  import pec_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  pec_mode_type mode = PEC_NSC;
  logic         internal_visibility = 1'b0, bus_clock_stretch = 1'b0, tag_enable = 1'b0, tag_req = 1'b0;
  logic         reg_wr = 1'b0, reg_rd = 1'b0, bus_clock = 1'b0;
  logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pin_in, pin_out, pin_oe, pin_pullup;
  logic         hi_pu, lo_pu, ctl_rd, lo_rd, hi_rd, tag;
  int           fail_count = 0, compares = 0, tag_cnt = 0;
  logic [7:0]   exp_rst [7] = '{8'h90, 8'h80, 8'h80, 8'h80, 8'hac, 8'hac, 8'h00};
  logic [7:0]   exp_oe [6] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h7c, 8'h7c};

  pec_top uut (.clk(clk), .sys_rst(sys_rst), .mode(mode), .internal_visibility(internal_visibility),
    .bus_clock_stretch(bus_clock_stretch), .tag_enable(tag_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_bus_enable(1'b1), .clock_module_test(1'b1), .pipe_status(2'b01), .bus_clock(bus_clock),
    .low_byte_strobe(1'b1), .read_write(1'b1), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .high_addr_port_pullup(hi_pu), .low_addr_port_pullup(lo_pu),
    .control_port_reduced_drive(ctl_rd), .low_addr_port_reduced_drive(lo_rd),
    .high_addr_port_reduced_drive(hi_rd), .low_byte_instruction_tag(tag));

  pec_far_side far (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .bus_clock(bus_clock), .tag_req(tag_req), .pin_in(pin_in));

  initial forever #25 clk = ~clk;
  always @(posedge clk) bus_clock <= ~bus_clock;
  always @(posedge clk) if (tag === 1'b1) tag_cnt++;

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, "register read");
  endtask

  task automatic do_reset(input pec_mode_type m);
    @(posedge clk);
    sys_rst <= 1'b1;
    mode <= m;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run is well under 1000 cycles
  initial begin
    #500000;
    fail_count++;
    $display("ERROR %0t ns: watchdog expired", $time);
    test_done;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    for (int m = 0; m < 7; m++) begin
      do_reset(pec_mode_type'(m));
      rd(8'h0a, exp_rst[m]);
      if (m < 6) begin
        settle;
        chk(pin_oe, exp_oe[m], "enables after reset");
      end
    end
    $display("Test reset values done");

    do_reset(PEC_NSC);
    wr(8'h0a, 8'h2c);
    wr(8'h0a, 8'h90);
    rd(8'h0a, 8'h2c);
    wr(8'h0c, 8'h13);
    rd(8'h0c, 8'h13);
    settle;
    chk(pin_oe, 8'h90, "single-chip roles");
    chk(pin_pullup, 8'h0f, "pullups on inputs");
    chk({6'h00, hi_pu, lo_pu}, 8'h03, "address port pullups");
    wr(8'h09, 8'hff);
    rd(8'h09, 8'hfc);
    settle;
    chk(pin_oe, 8'hfc, "direction outputs");
    chk(pin_pullup, 8'h03, "pullups on outputs");
    wr(8'h08, 8'h24);
    settle;
    chk(pin_out & 8'hec, 8'ha4, "data and data enable levels");
    wr(8'h0d, 8'h13);
    wr(8'h0d, 8'h00);
    rd(8'h0d, 8'h13);
    settle;
    chk({5'h00, ctl_rd, lo_rd, hi_rd}, 8'h07, "reduced drive");
    rd(8'h40, 8'h00);
    $display("Test normal single-chip done");

    do_reset(PEC_SEXW);
    settle;
    chk(pin_out & 8'h64, 8'h24, "pipe and read/write levels");
    wr(8'h0a, 8'h00);
    rd(8'h0a, 8'hac);
    wr(8'h0a, 8'h5c);
    rd(8'h0a, 8'h4c);
    settle;
    chk(pin_oe, 8'hdc, "special expanded roles");
    chk(pin_out & 8'hcc, 8'hcc, "clock test level");
    wr(8'h0a, 8'h6c);
    settle;
    chk(pin_out & 8'h64, 8'h24, "pipe over clock test");
    wr(8'h0c, 8'h13);
    settle;
    chk({6'h00, hi_pu, lo_pu}, 8'h00, "bus port pullups");
    wr(8'h0d, 8'h13);
    rd(8'h0d, 8'h00);
    wr(8'h0d, 8'h13);
    wr(8'h0d, 8'h01);
    rd(8'h0d, 8'h01);
    settle;
    chk({5'h00, ctl_rd, lo_rd, hi_rd}, 8'h01, "special reduced drive");
    @(posedge clk);
    tag_enable <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk(8'(tag_cnt), 8'h00, "no tag while pin 3 stays high");
    @(posedge clk);
    tag_req <= 1'b1;
    repeat (20) @(posedge clk);
    tag_req <= 1'b0;
    #1 chk(8'(tag_cnt > 0), 8'h01, "instruction tag seen");
    $display("Test special expanded done");

    do_reset(PEC_NEXN);
    wr(8'h0a, 8'h4c);
    rd(8'h0a, 8'h4c);
    settle;
    chk(pin_oe, 8'h94, "narrow expanded roles");
    $display("Test normal expanded done");

    do_reset(PEC_SSC);
    wr(8'h0a, 8'h7c);
    rd(8'h0a, 8'h90);
    wr(8'h0a, 8'h24);
    rd(8'h0a, 8'h24);
    bus_clock_stretch <= 1'b1;
    settle;
    chk(pin_oe & 8'h10, 8'h00, "stretched bus clock off");
    internal_visibility <= 1'b1;
    settle;
    chk(pin_oe & 8'h10, 8'h10, "visible bus clock on");
    $display("Test special single-chip done");

    do_reset(PEC_PER);
    wr(8'h0a, 8'h00);
    rd(8'h0a, 8'h00);
    wr(8'h0c, 8'h13);
    rd(8'h0c, 8'h00);
    wr(8'h0d, 8'h13);
    rd(8'h0d, 8'h00);
    settle;
    chk({5'h00, ctl_rd, lo_rd, hi_rd}, 8'h00, "peripheral drive");
    $display("Test peripheral done");
    test_done;
  end
endmodule
`default_nettype wire
